// *** bench/bsc_scan_assertions.sv ***
/*
 Port checker of the boundary scan block.
 Assumes it is bound to bsc_scan and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module bsc_scan_assertions (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic        cfg_done,
  input wire logic [11:0] pin_mode,
  input wire logic [1:0]  diff_pair,
  input wire logic [3:0]  core_oe,
  input wire logic [3:0]  pad_out,
  input wire logic [3:0]  pad_oe,
  input wire logic [3:0]  pad_pull_dn
);
  wire c1 = cfg_done && pin_mode[5:3] == 3'h1 && !diff_pair[0] && !core_oe[1];
  wire c3 = cfg_done && pin_mode[11:9] == 3'h1 && !diff_pair[1]
            && !core_oe[3];
  wire cu = cfg_done && pin_mode[2:0] != 3'h0;
  wire cp = cfg_done && diff_pair[0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_in_n1; $past(c1) && $past(c1, 2) |-> !pad_oe[1]; endproperty
  property p_in_n3; $past(c3) && $past(c3, 2) |-> !pad_oe[3]; endproperty
  property p_pull_used;
    $past(cu) && $past(cu, 2) |-> !pad_pull_dn[0];
  endproperty
  property p_pair_inv;
    $past(cp) && $past(cp, 2) && pad_oe[1] |->
      pad_oe[0] && pad_out[1] != pad_out[0];
  endproperty
  property p_tdo_fall; $changed(tdo) |-> !$past(tck, 2); endproperty
  property p_tdo_shift; $changed(tdo) |-> tdo_oe; endproperty
  property p_oe_fall; $changed(tdo_oe) |-> !$past(tck, 2); endproperty
  property p_oe_hold; $rose(tdo_oe) |-> tdo_oe [*8]; endproperty
  a_in_n1: assert property (p_in_n1) else $error("pin 1 driven");
  a_in_n3: assert property (p_in_n3) else $error("pin 3 driven");
  a_pull_used: assert property (p_pull_used) else $error("pull on");
  a_pair_inv: assert property (p_pair_inv) else $error("pair drive");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo edge");
  a_tdo_shift: assert property (p_tdo_shift) else $error("tdo idle");
  a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe edge");
  a_oe_hold: assert property (p_oe_hold) else $error("tdo_oe short");
  c_shift: cover property ($rose(tdo_oe));
  c_pull: cover property ($rose(pad_pull_dn[3]));
  c_pair: cover property (cp && pad_oe[1]);
endmodule
bind bsc_scan bsc_scan_assertions i_bsc_scan_assertions (.sys_clk, .rstn,
  .tck, .tdo, .tdo_oe, .cfg_done, .pin_mode, .diff_pair, .core_oe,
  .pad_out, .pad_oe, .pad_pull_dn);
`default_nettype wire

// *** bench/bsc_scan_bench.sv ***
/*
 Self-checking bench of bsc_scan with a tester model.
 Assumes the bench drives pads wherever the block does not.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"
module bsc_scan_bench;
  import bsc_pkg::*;
  typedef struct packed {
    logic       cfg;
    logic [1:0] pr;
    logic [11:0] md;
    logic [3:0] ctl, dat, oe, out, pd;
  } bsc_row_t;
  logic sys_clk, rstn, tck, tms, tdi, tdo, tdo_oe, cfg_done, o;
  logic [11:0] pin_mode;
  logic [1:0] diff_pair;
  logic [3:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [3:0] pad_pull_dn, ext;
  logic [23:0] cap, v;
  int n_fail, checked;
  bsc_row_t rows [5];
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
  bsc_scan i_bsc_scan (.sys_clk, .rstn, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .cfg_done, .pin_mode, .diff_pair, .core_out, .core_oe, .core_in,
    .pad_in, .pad_out, .pad_oe, .pad_pull_dn);
  bsc_tester i_bsc_tester (.sys_clk, .tdo, .tck, .tms, .tdi);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200000 n_fail++;
    end_of_test();
  end
  initial begin
    {rstn, cfg_done, pin_mode, diff_pair, core_out, core_oe, ext} = '0;
    n_fail = 0;
    checked = 0;
    rows[0] = '{1'h1, 2'h0, 12'h0CA, 4'h0, 4'h5, 4'hD, 4'h5, 4'h0};
    rows[1] = '{1'h1, 2'h0, 12'h0CA, 4'hF, 4'hA, 4'h0, 4'h0, 4'h8};
    rows[2] = '{1'h1, 2'h1, 12'h8A4, 4'h2, 4'h7, 4'hF, 4'h5, 4'h0};
    rows[3] = '{1'h0, 2'h3, 12'h249, 4'h0, 4'h3, 4'hF, 4'h3, 4'h0};
    rows[4] = '{1'h0, 2'h0, 12'h249, 4'hF, 4'h0, 4'h0, 4'h0, 4'hF};
    repeat (8) @(posedge sys_clk);
    #1 chk("rst", {tdo, tdo_oe, pad_oe, pad_out, pad_pull_dn, core_in},
           24'h0);
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    i_bsc_tester.step(1'b0, 1'b0, o);
    i_bsc_tester.scan(1'b1, 24'h0, 5, cap);
    chk("ir", cap, 24'h000001);
    foreach (rows[r]) begin
      {cfg_done, diff_pair, pin_mode} = {rows[r].cfg, rows[r].pr, rows[r].md};
      v = '0;
      for (int i = 0; i < 4; i++) {v[3*i+1], v[3*i]} = {rows[r].dat[i],
                                                       rows[r].ctl[i]};
      i_bsc_tester.scan(1'b0, v, 12, cap);
      repeat (3) @(posedge sys_clk);
      #1 chk("oe", {20'h0, pad_oe}, {20'h0, rows[r].oe});
      chk("out", {20'h0, pad_out & rows[r].oe}, {20'h0, rows[r].out});
      chk("pd", {20'h0, pad_pull_dn}, {20'h0, rows[r].pd});
      $display("row %0d done", r);
    end
    {cfg_done, diff_pair, pin_mode, ext} = {1'b1, 2'h1, 12'h2A4, 4'h9};
    i_bsc_tester.scan(1'b1, 24'h1, 5, cap);
    i_bsc_tester.scan(1'b0, 24'h0, 12, cap);
    chk("cap", {21'h0, cap[11], cap[8], cap[2]}, 24'h5);
    chk("cin", {20'h0, core_in}, 24'h9);
    $display("capture done");
    for (int k = 0; k < 2; k++) begin
      cfg_done = k[0];
      i_bsc_tester.scan(1'b0, 24'h000A5C, 24, cap);
      chk("len", {12'h0, cap[23:12]}, 24'h000A5C);
    end
    $display("chain done");
    cfg_done = 1'b1;
    i_bsc_tester.scan(1'b1, 24'h0, 5, cap);
    repeat (3) @(posedge sys_clk);
    #1 chk("ext", {20'h0, pad_oe}, 24'h7);
    i_bsc_tester.tlr();
    repeat (3) @(posedge sys_clk);
    #1 chk("tlr", {20'h0, pad_oe}, 24'h0);
    $display("reset done");
    {core_oe, core_out} = {4'h5, 4'h1};
    repeat (3) @(posedge sys_clk);
    #1 chk("func", {16'h0, pad_oe, pad_out & pad_oe}, 24'h71);
    rstn = 1'b0;
    @(posedge sys_clk);
    #1 chk("rst2", {tdo, tdo_oe, pad_oe, pad_out, pad_pull_dn, core_in},
           24'h0);
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    i_bsc_tester.step(1'b0, 1'b0, o);
    i_bsc_tester.scan(1'b1, 24'h0, 5, cap);
    chk("ir2", cap, 24'h000001);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** bench/bsc_tester.sv ***
/*
 Boundary scan tester model: one tck per step call, 80 ns period.
 Assumes sys_clk runs at 10 ns; tck stands low between calls.
*/
`timescale 1ns/100ps
`default_nettype none
module bsc_tester (
  input  wire logic sys_clk,
  input  wire logic tdo,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge sys_clk);
    #1 tms = m;
    tdi = d;
    repeat (3) @(posedge sys_clk);
    #1 tck = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 o = tdo;
    @(posedge sys_clk);
    #1 tck = 1'b0;
  endtask
  task automatic scan(input logic ir, input logic [23:0] v, input int n,
                      output logic [23:0] c);
    logic o;
    c = 24'h000000;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) step(i == n - 1, v[i], c[i]);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule
`default_nettype wire

// *** logic/bsc_defs.svh ***
/*
 Constants of the post-configuration boundary scan block: chain sizes,
 instruction codes, pin mode codes and safe values.
 Assumes it is included by bare name, once or more, before use.
*/
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

`define BSC_NIOB        4
`define BSC_NPAIR       2
`define BSC_LEN         12
`define BSC_IR_LEN      5
`define BSC_IR_CAPTURE  5'h01
`define BSC_OP_EXTEST   5'h00
`define BSC_OP_SAMPLE   5'h01
`define BSC_OP_BYPASS   5'h1F
`define BSC_MODE_W      3
`define BSC_MODE_UNUSED 3'h0
`define BSC_MODE_INPUT  3'h1
`define BSC_MODE_OUTPUT 3'h2
`define BSC_MODE_TRIST  3'h3
`define BSC_MODE_BIDIR  3'h4
`define BSC_CTL_SAFE    1'b1
// Update latches at reset: control cells safe, others zero
`define BSC_UPD_RST     12'h249

`endif

// *** logic/bsc_pkg.sv ***
/*
 Types of the boundary scan block: the test access port state.
 Assumes nothing of its surroundings.
*/
package bsc_pkg;
  typedef enum logic [3:0] {
    BSC_TLR, BSC_RTI, BSC_SEL_DR, BSC_CAP_DR, BSC_SH_DR, BSC_EX1_DR,
    BSC_PAU_DR, BSC_EX2_DR, BSC_UPD_DR, BSC_SEL_IR, BSC_CAP_IR,
    BSC_SH_IR, BSC_EX1_IR, BSC_PAU_IR, BSC_EX2_IR, BSC_UPD_IR
  } bsc_tap_t;
endpackage

// *** logic/bsc_scan.sv ***
/*
 Test access port with a boundary register of three cells per I/O block,
 whose pad connection follows the configured pin direction.
 Assumes tck, tms, tdi and pad_in come from outside the sys_clk domain;
 even pins are P sides and odd pins the N sides of possible pairs.
*/
// Notes on behaviour
// - Three latched cells per I/O block
// - Input pins: scan never drives pad
// - Output pins keep input cell on pad
// - Pair uses P-side control and output cells
// - N-side cells stay chained, pad detached
// - N pad driven inverse of P value
// - Control cell one disables output, high-Z
// - Unused pin pulled down when disabled
// - Five-bit instruction, captures pattern 01
// - No test reset pin; mode sequence only
// - Unconfigured: every pin bidirectional scan
// - Unconfigured pair pins act single-ended
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"

module bsc_scan
  import bsc_pkg::*;
(
  input  wire logic                                 sys_clk,
  input  wire logic                                 rstn,
  input  wire logic                                 tck,
  input  wire logic                                 tms,
  input  wire logic                                 tdi,
  output logic                                      tdo,
  output logic                                      tdo_oe,
  input  wire logic                                 cfg_done,
  input  wire logic [`BSC_NIOB*`BSC_MODE_W-1:0]     pin_mode,
  input  wire logic [`BSC_NPAIR-1:0]                diff_pair,
  input  wire logic [`BSC_NIOB-1:0]                 core_out,
  input  wire logic [`BSC_NIOB-1:0]                 core_oe,
  output logic [`BSC_NIOB-1:0]                      core_in,
  input  wire logic [`BSC_NIOB-1:0]                 pad_in,
  output logic [`BSC_NIOB-1:0]                      pad_out,
  output logic [`BSC_NIOB-1:0]                      pad_oe,
  output logic [`BSC_NIOB-1:0]                      pad_pull_dn
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and test clock edges

  logic [2:0]             sync1_ff;
  logic [2:0]             sync2_ff;
  logic                   tck_prev_ff;
  logic [`BSC_NIOB-1:0]   pad_s1_ff;
  logic [`BSC_NIOB-1:0]   pad_s2_ff;
  logic                   tck_rise;
  logic                   tck_fall;
  logic                   tms_s;
  logic                   tdi_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff    <= 3'h0;
      sync2_ff    <= 3'h0;
      tck_prev_ff <= 1'b0;
      pad_s1_ff   <= '0;
      pad_s2_ff   <= '0;
    end else begin
      sync1_ff    <= {tck, tms, tdi};
      sync2_ff    <= sync1_ff;
      tck_prev_ff <= sync2_ff[2];
      pad_s1_ff   <= pad_in;
      pad_s2_ff   <= pad_s1_ff;
    end
  end

  assign tck_rise = sync2_ff[2] & ~tck_prev_ff;
  assign tck_fall = ~sync2_ff[2] & tck_prev_ff;
  assign tms_s    = sync2_ff[1];
  assign tdi_s    = sync2_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // Per-pin cell connection

  logic [`BSC_LEN-1:0]    upd_ff;
  logic [`BSC_LEN-1:0]    cap;
  logic [`BSC_NIOB-1:0]   nxt_pad_out;
  logic [`BSC_NIOB-1:0]   nxt_pad_oe;
  logic [`BSC_NIOB-1:0]   nxt_pull;
  logic [`BSC_IR_LEN-1:0] ir_ff;
  logic                   extest;

  assign extest = (ir_ff == `BSC_OP_EXTEST);

  genvar gi;
  generate
    for (gi = 0; gi < `BSC_NIOB; gi = gi + 1) begin : g_pin
      localparam int PS = gi - (gi % 2);
      localparam bit IS_N = (gi % 2) == 1;
      logic                   diff;
      logic                   ndet;
      logic [`BSC_MODE_W-1:0] mode;
      logic [`BSC_MODE_W-1:0] cmode;
      logic                   ctl;
      logic                   outv;
      logic                   drv_ok;
      logic                   inv;
      logic                   cout;
      logic                   coe;
      logic                   spare;
      assign diff  = cfg_done & diff_pair[gi/2];
      assign cmode = cfg_done ? pin_mode[gi*`BSC_MODE_W +: `BSC_MODE_W]
                              : `BSC_MODE_BIDIR;
      assign mode  = diff ? pin_mode[PS*`BSC_MODE_W +: `BSC_MODE_W] : cmode;
      assign ndet  = diff & IS_N;
      assign ctl   = diff ? upd_ff[3*PS]   : upd_ff[3*gi];
      assign outv  = diff ? upd_ff[3*PS+1] : upd_ff[3*gi+1];
      assign cout  = diff ? core_out[PS]   : core_out[gi];
      assign coe   = diff ? core_oe[PS]    : core_oe[gi];
      assign drv_ok = (mode != `BSC_MODE_INPUT);
      assign inv   = ndet;
      assign spare = (mode == `BSC_MODE_UNUSED);
      always_comb begin
        nxt_pad_oe[gi]  = drv_ok & (extest ? ~ctl : coe);
        nxt_pad_out[gi] = (extest ? outv : cout) ^ inv;
        nxt_pull[gi]    = extest ? ((spare | ~cfg_done) & ctl) : spare;
      end
      assign cap[3*gi]   = (ndet | !drv_ok) ? upd_ff[3*gi]   : ~coe;
      assign cap[3*gi+1] = (ndet | !drv_ok) ? upd_ff[3*gi+1] : cout;
      assign cap[3*gi+2] = ndet ? upd_ff[3*gi+2] : pad_s2_ff[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pad_out     <= '0;
      pad_oe      <= '0;
      pad_pull_dn <= '0;
      core_in     <= '0;
    end else begin
      pad_out     <= nxt_pad_out;
      pad_oe      <= nxt_pad_oe;
      pad_pull_dn <= nxt_pull;
      core_in     <= pad_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Test access port state, instruction and data registers

  bsc_tap_t               tap_ff;
  bsc_tap_t               nxt_tap;
  logic [`BSC_IR_LEN-1:0] irsh_ff;
  logic [`BSC_IR_LEN-1:0] nxt_irsh;
  logic [`BSC_IR_LEN-1:0] nxt_ir;
  logic [`BSC_LEN-1:0]    bsr_ff;
  logic [`BSC_LEN-1:0]    nxt_bsr;
  logic [`BSC_LEN-1:0]    nxt_upd;
  logic                   byp_ff;
  logic                   nxt_byp;
  logic                   nxt_tdo;
  logic                   nxt_tdo_oe;
  logic                   bsr_sel;

  assign bsr_sel = (ir_ff == `BSC_OP_EXTEST) | (ir_ff == `BSC_OP_SAMPLE);

  always_comb begin
    nxt_tap = tap_ff;
    unique case (tap_ff)
      BSC_TLR:    nxt_tap = tms_s ? BSC_TLR    : BSC_RTI;
      BSC_RTI:    nxt_tap = tms_s ? BSC_SEL_DR : BSC_RTI;
      BSC_SEL_DR: nxt_tap = tms_s ? BSC_SEL_IR : BSC_CAP_DR;
      BSC_CAP_DR: nxt_tap = tms_s ? BSC_EX1_DR : BSC_SH_DR;
      BSC_SH_DR:  nxt_tap = tms_s ? BSC_EX1_DR : BSC_SH_DR;
      BSC_EX1_DR: nxt_tap = tms_s ? BSC_UPD_DR : BSC_PAU_DR;
      BSC_PAU_DR: nxt_tap = tms_s ? BSC_EX2_DR : BSC_PAU_DR;
      BSC_EX2_DR: nxt_tap = tms_s ? BSC_UPD_DR : BSC_SH_DR;
      BSC_UPD_DR: nxt_tap = tms_s ? BSC_SEL_DR : BSC_RTI;
      BSC_SEL_IR: nxt_tap = tms_s ? BSC_TLR    : BSC_CAP_IR;
      BSC_CAP_IR: nxt_tap = tms_s ? BSC_EX1_IR : BSC_SH_IR;
      BSC_SH_IR:  nxt_tap = tms_s ? BSC_EX1_IR : BSC_SH_IR;
      BSC_EX1_IR: nxt_tap = tms_s ? BSC_UPD_IR : BSC_PAU_IR;
      BSC_PAU_IR: nxt_tap = tms_s ? BSC_EX2_IR : BSC_PAU_IR;
      BSC_EX2_IR: nxt_tap = tms_s ? BSC_UPD_IR : BSC_SH_IR;
      BSC_UPD_IR: nxt_tap = tms_s ? BSC_SEL_DR : BSC_RTI;
    endcase
    if (!tck_rise)
      nxt_tap = tap_ff;

    nxt_irsh   = irsh_ff;
    nxt_ir     = ir_ff;
    nxt_bsr    = bsr_ff;
    nxt_byp    = byp_ff;
    nxt_upd    = upd_ff;
    nxt_tdo    = tdo;
    nxt_tdo_oe = tdo_oe;
    if (tck_rise) begin
      unique case (tap_ff)
        // Capture pattern with low bits 01
        BSC_CAP_IR: nxt_irsh = `BSC_IR_CAPTURE;
        BSC_SH_IR:  nxt_irsh = {tdi_s, irsh_ff[`BSC_IR_LEN-1:1]};
        BSC_CAP_DR: begin
          nxt_bsr = bsr_sel ? cap : bsr_ff;
          nxt_byp = 1'b0;
        end
        BSC_SH_DR: begin
          if (bsr_sel)
            nxt_bsr = {tdi_s, bsr_ff[`BSC_LEN-1:1]};
          else
            nxt_byp = tdi_s;
        end
        default: ;
      endcase
    end
    if (tck_fall) begin
      unique case (tap_ff)
        BSC_TLR:    nxt_ir = `BSC_OP_BYPASS;
        BSC_UPD_IR: nxt_ir = irsh_ff;
        BSC_UPD_DR: nxt_upd = bsr_sel ? bsr_ff : upd_ff;
        default: ;
      endcase
      nxt_tdo_oe = (tap_ff == BSC_SH_DR) | (tap_ff == BSC_SH_IR);
      if (tap_ff == BSC_SH_IR)
        nxt_tdo = irsh_ff[0];
      else if (tap_ff == BSC_SH_DR)
        nxt_tdo = bsr_sel ? bsr_ff[0] : byp_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tap_ff  <= BSC_TLR;
      irsh_ff <= `BSC_IR_CAPTURE;
      ir_ff   <= `BSC_OP_BYPASS;
      bsr_ff  <= '0;
      byp_ff  <= 1'b0;
      upd_ff  <= `BSC_UPD_RST;
      tdo     <= 1'b0;
      tdo_oe  <= 1'b0;
    end else begin
      tap_ff  <= nxt_tap;
      irsh_ff <= nxt_irsh;
      ir_ff   <= nxt_ir;
      bsr_ff  <= nxt_bsr;
      byp_ff  <= nxt_byp;
      upd_ff  <= nxt_upd;
      tdo     <= nxt_tdo;
      tdo_oe  <= nxt_tdo_oe;
    end
  end

endmodule

`default_nettype wire
